// file: logic/mch_pkg.sv
// shared constants and types of the output coil request handler
package mch_pkg;

  // function codes served by the handler
  localparam logic [7:0] FC_WRITE_COIL = 8'h05;
  localparam logic [7:0] FC_PRESET_REG = 8'h06;
  localparam logic [7:0] FC_READ_EXC = 8'h07;
  localparam logic [7:0] FC_WRITE_COILS = 8'h0F;

  // exception flag position in the function code, and exception codes
  localparam int EXC_FLAG_BIT = 7;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
  localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
  localparam logic [7:0] EXC_NONE = 8'h00;

  // coil values, address and quantity limits
  localparam logic [15:0] COIL_ON = 16'hFF00;
  localparam logic [15:0] COIL_OFF = 16'h0000;
  localparam logic [15:0] LAST_COIL = 16'h000F;
  localparam logic [15:0] PRESET_ADDR = 16'h0000;
  localparam logic [15:0] QTY_MIN = 16'h0001;
  localparam logic [15:0] QTY_MAX = 16'h0010;
  localparam logic [16:0] COIL_END = 17'h00010;

  // output width and reset value
  localparam int NUM_OUT = 16;
  localparam logic [15:0] OUT_RESET = 16'h0000;

  // request byte positions inside a frame
  localparam int POS_FC = 0;
  localparam int POS_ADDR_HI = 1;
  localparam int POS_ADDR_LO = 2;
  localparam int POS_VAL_HI = 3;
  localparam int POS_VAL_LO = 4;
  localparam int POS_BCOUNT = 5;
  localparam int POS_DATA0 = 6;
  localparam int POS_DATA1 = 7;

  // buffer sizes and frame lengths in bytes
  localparam int RX_BYTES = 8;
  localparam int RX_IDX_W = 3;
  localparam int TX_BYTES = 5;
  localparam logic [3:0] RX_CNT_MAX = 4'hF;
  localparam logic [3:0] LEN_FIXED = 4'h5;
  localparam logic [3:0] LEN_COILS_HDR = 4'h6;
  localparam logic [2:0] LEN_ECHO = 3'h5;
  localparam logic [2:0] LEN_EXC = 3'h2;
  localparam logic [2:0] LEN_STATUS = 3'h2;

  // slave request state machine, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RECV = 4'h2,
    ST_EXEC = 4'h4,
    ST_SEND = 4'h8
  } mch_state_type;

endpackage

// file: logic/mch_resp_capture.sv
// capture of response function code, exception code and status byte in master role
module mch_resp_capture (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // response byte stream from the remote slave
  input wire logic mstValid,
  input wire logic [7:0] mstData,
  input wire logic mstLast,
  // destination slot named by the issuing command
  input wire logic [7:0] mstDestIndex,
  // kept results
  output logic [7:0] responseFunctionCodeQuery,
  output logic [7:0] responseExceptionCodeQuery,
  // destination array write
  output logic arrayWrite,
  output logic [7:0] arrayIndex,
  output logic [7:0] arrayData
);

  logic [1:0] byteIdx_reg, byteIdx_next; // position inside the response
  logic [7:0] func_reg, func_next; // last response function code
  logic [7:0] exc_reg, exc_next; // last exception code
  logic wr_reg, wr_next; // one-cycle array write strobe
  logic [7:0] idx_reg, idx_next; // array slot
  logic [7:0] dat_reg, dat_next; // array data

  // next-state logic of the capture
  always_comb begin
    byteIdx_next = byteIdx_reg;
    func_next = func_reg;
    exc_next = exc_reg;
    wr_next = 1'b0;
    idx_next = idx_reg;
    dat_next = dat_reg;
    if (mstValid) begin
      if (byteIdx_reg == 2'd0) begin
        // every response leaves its function code for query
        func_next = mstData;
        if (!mstData[mch_pkg::EXC_FLAG_BIT]) begin
          exc_next = mch_pkg::EXC_NONE; // normal answer clears the old code
        end
      end else if (byteIdx_reg == 2'd1) begin
        if (func_reg[mch_pkg::EXC_FLAG_BIT]) begin
          exc_next = mstData; // exception code kept
        end else if (func_reg == mch_pkg::FC_READ_EXC) begin
          // status byte goes to the named array slot
          wr_next = 1'b1;
          idx_next = mstDestIndex;
          dat_next = mstData;
        end
      end
      // saturate so long answers never wrap onto the code slot
      if (mstLast) begin
        byteIdx_next = 2'd0;
      end else if (byteIdx_reg != 2'd3) begin
        byteIdx_next = byteIdx_reg + 2'd1;
      end
    end
  end

  // registers of the capture
  always_ff @(posedge clk) begin
    if (rst) begin
      byteIdx_reg <= 2'd0;
      func_reg <= 8'h00;
      exc_reg <= 8'h00;
      wr_reg <= 1'b0;
      idx_reg <= 8'h00;
      dat_reg <= 8'h00;
    end else begin
      byteIdx_reg <= byteIdx_next;
      func_reg <= func_next;
      exc_reg <= exc_next;
      wr_reg <= wr_next;
      idx_reg <= idx_next;
      dat_reg <= dat_next;
    end
  end

  assign responseFunctionCodeQuery = func_reg;
  assign responseExceptionCodeQuery = exc_reg;
  assign arrayWrite = wr_reg;
  assign arrayIndex = idx_reg;
  assign arrayData = dat_reg;

endmodule // mch_resp_capture

// file: logic/mch_coil_handler.sv
// request handler for the sixteen digital outputs, slave and master roles
module mch_coil_handler (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request byte stream from the remote master
  input wire logic reqValid,
  input wire logic [7:0] reqData,
  input wire logic reqLast,
  output logic reqReady,
  // response byte stream to the remote master
  output logic rspValid,
  output logic [7:0] rspData,
  output logic rspLast,
  input wire logic rspReady,
  // digital outputs
  output logic [15:0] digitalOut,
  output logic outputsUpdated,
  // response byte stream seen while this unit is master
  input wire logic mstValid,
  input wire logic [7:0] mstData,
  input wire logic mstLast,
  input wire logic [7:0] mstDestIndex,
  // master-role results
  output logic [7:0] responseFunctionCodeQuery,
  output logic [7:0] responseExceptionCodeQuery,
  output logic arrayWrite,
  output logic [7:0] arrayIndex,
  output logic [7:0] arrayData
);

  // request state
  mch_pkg::mch_state_type state_reg, state_next;
  logic [7:0] rxBuf_reg [mch_pkg::RX_BYTES]; // received request bytes
  logic [7:0] rxBuf_next [mch_pkg::RX_BYTES];
  logic [3:0] rxCount_reg, rxCount_next; // bytes seen, saturating
  // response state
  logic [7:0] txBuf_reg [mch_pkg::TX_BYTES]; // response shift buffer
  logic [7:0] txBuf_next [mch_pkg::TX_BYTES];
  logic [2:0] txLeft_reg, txLeft_next; // bytes still to send
  // output state
  logic [15:0] out_reg, out_next; // driven output levels
  logic upd_reg, upd_next; // one-cycle change strobe

  // frame handling in brief:
  //   idle and recv gather bytes until the marked last one arrives
  //   exec evaluates the whole frame once, in a single cycle
  //   send shifts the answer out, one byte per accepted beat
  // the request port stays closed from exec until the final answer byte
  // is taken, so a master that streams back to back only ever waits here
  // outputs and answer are loaded on the same edge; a consumer that sees
  // the first answer byte can trust the outputs already show the request
  // trade-off: no second frame is buffered while an answer is pending,
  // which keeps the storage small at the cost of some turnaround time

  // decoded request fields
  logic [7:0] reqFunc; // function code
  logic [15:0] reqAddr; // starting address
  logic [15:0] reqValue; // output value, register value or quantity
  logic [7:0] reqByteCount; // coil data byte count
  logic [15:0] coilBits; // packed coil data, first coil in bit 0
  logic [16:0] coilEnd; // start plus quantity
  logic [15:0] coilSel; // outputs reached by a multiple write
  logic [15:0] coilVal; // value for each reached output
  // fields come straight from the buffer slots; addresses and quantities
  // arrive high byte first, coil data low coil first

  // results of execution
  logic [7:0] execBuf [mch_pkg::TX_BYTES];
  logic [2:0] execLen; // response length in bytes
  logic [15:0] execOut; // output levels after the request
  logic execUpd; // outputs were written
  // exec results are combinational and only matter in the exec state

  assign reqFunc = rxBuf_reg[mch_pkg::POS_FC];
  assign reqAddr = {rxBuf_reg[mch_pkg::POS_ADDR_HI], rxBuf_reg[mch_pkg::POS_ADDR_LO]};
  assign reqValue = {rxBuf_reg[mch_pkg::POS_VAL_HI], rxBuf_reg[mch_pkg::POS_VAL_LO]};
  assign reqByteCount = rxBuf_reg[mch_pkg::POS_BCOUNT];
  // first data byte holds the lowest coils, lsb first
  assign coilBits = {rxBuf_reg[mch_pkg::POS_DATA1], rxBuf_reg[mch_pkg::POS_DATA0]};
  assign coilEnd = {1'b0, reqAddr} + {1'b0, reqValue};

  // the selection window is start up to start plus quantity minus one;
  // outputs outside it keep their level, so a partial write never
  // disturbs its neighbours; offs wraps below the window, which is
  // harmless because coilSel masks those outputs off
  // per-output selection for a multiple coil write
  for (genvar g = 0; g < mch_pkg::NUM_OUT; g++) begin : gen_coil
    logic [3:0] offs; // coil position inside the request data
    assign offs = 4'(g) - reqAddr[3:0];
    assign coilSel[g] = (17'(g) >= {1'b0, reqAddr}) && (17'(g) < coilEnd);
    assign coilVal[g] = coilBits[offs];
  end

  // execution of a complete request
  always_comb begin
    for (int i = 0; i < mch_pkg::TX_BYTES; i++) begin
      execBuf[i] = 8'h00;
    end
    execLen = mch_pkg::LEN_EXC;
    execOut = out_reg;
    execUpd = 1'b0;
    // every path below starts from the exception answer and no change
    // checks run in a fixed order: length, address, then value or quantity;
    // the first one that fails picks the code, so a short frame never
    // reaches the address test with stale buffer bytes
    // default answer is an exception, outputs untouched
    execBuf[0] = reqFunc | mch_pkg::EXC_FLAG;
    execBuf[1] = mch_pkg::EXC_ILLEGAL_FUNC;
    unique case (reqFunc)
      mch_pkg::FC_WRITE_COIL: begin
        // only the two exact coil codes act; anything else is refused
        if (rxCount_reg < mch_pkg::LEN_FIXED) begin
          execBuf[1] = mch_pkg::EXC_ILLEGAL_VALUE; // truncated frame
        end else if (reqAddr > mch_pkg::LAST_COIL) begin
          execBuf[1] = mch_pkg::EXC_ILLEGAL_ADDR;
        end else if (reqValue == mch_pkg::COIL_ON || reqValue == mch_pkg::COIL_OFF) begin
          // addressed output follows the value
          execOut[reqAddr[3:0]] = (reqValue == mch_pkg::COIL_ON);
          execUpd = 1'b1;
          for (int i = 0; i < mch_pkg::TX_BYTES; i++) begin
            execBuf[i] = rxBuf_reg[i]; // echo
          end
          execLen = mch_pkg::LEN_ECHO;
        end else begin
          execBuf[1] = mch_pkg::EXC_ILLEGAL_VALUE; // not a command, no change
        end
      end
      mch_pkg::FC_PRESET_REG: begin
        // all sixteen outputs are replaced together, never bit by bit
        if (rxCount_reg < mch_pkg::LEN_FIXED) begin
          execBuf[1] = mch_pkg::EXC_ILLEGAL_VALUE;
        end else if (reqAddr != mch_pkg::PRESET_ADDR) begin
          execBuf[1] = mch_pkg::EXC_ILLEGAL_ADDR;
        end else begin
          execOut = reqValue; // bit n drives output n
          execUpd = 1'b1;
          for (int i = 0; i < mch_pkg::TX_BYTES; i++) begin
            execBuf[i] = rxBuf_reg[i]; // echo
          end
          execLen = mch_pkg::LEN_ECHO;
        end
      end
      mch_pkg::FC_READ_EXC: begin
        // read only: a bare function code is already a complete request
        // limitation: outputs 8-15 are not reported by this answer
        // status answer carries outputs 0-7, lsb is output 0
        execBuf[0] = mch_pkg::FC_READ_EXC;
        execBuf[1] = out_reg[7:0];
        execLen = mch_pkg::LEN_STATUS;
      end
      mch_pkg::FC_WRITE_COILS: begin
        if (rxCount_reg < mch_pkg::LEN_COILS_HDR) begin
          execBuf[1] = mch_pkg::EXC_ILLEGAL_VALUE;
        end else if (reqAddr > mch_pkg::LAST_COIL) begin
          execBuf[1] = mch_pkg::EXC_ILLEGAL_ADDR;
        end else if (reqValue < mch_pkg::QTY_MIN || reqValue > mch_pkg::QTY_MAX
                     || coilEnd > mch_pkg::COIL_END) begin
          execBuf[1] = mch_pkg::EXC_ILLEGAL_ADDR;
          // quantity is bounded here, so the byte count sum below
          // cannot overflow its sixteen-bit width
        end else if (reqByteCount != 8'((reqValue + 16'h0007) >> 3)
                     || rxCount_reg < 4'(mch_pkg::LEN_COILS_HDR + reqByteCount[3:0])) begin
          // data missing or byte count not matching the quantity
          execBuf[1] = mch_pkg::EXC_ILLEGAL_VALUE;
        end else begin
          execOut = (out_reg & ~coilSel) | (coilVal & coilSel);
          execUpd = 1'b1;
          // function, start and quantity copied unchanged
          for (int i = 0; i < mch_pkg::TX_BYTES; i++) begin
            execBuf[i] = rxBuf_reg[i];
          end
          execLen = mch_pkg::LEN_ECHO;
        end
      end
      default: begin
        // codes outside the served set leave every output as it was
        execBuf[1] = mch_pkg::EXC_ILLEGAL_FUNC; // unsupported function
      end
    endcase
  end

  // the buffer is not cleared between frames; every field that is read
  // is guarded by the byte count, so leftovers from an earlier request
  // cannot leak into a shorter one
  // request and response sequencing
  always_comb begin
    state_next = state_reg;
    rxBuf_next = rxBuf_reg;
    rxCount_next = rxCount_reg;
    txBuf_next = txBuf_reg;
    txLeft_next = txLeft_reg;
    out_next = out_reg;
    upd_next = 1'b0;
    unique case (state_reg)
      mch_pkg::ST_IDLE, mch_pkg::ST_RECV: begin
        if (reqValid) begin
          // the count saturates so a runaway frame never wraps to a short length
          // bytes past the buffer are counted but dropped
          if (rxCount_reg < 4'(mch_pkg::RX_BYTES)) begin
            rxBuf_next[rxCount_reg[mch_pkg::RX_IDX_W-1:0]] = reqData;
          end
          if (rxCount_reg != mch_pkg::RX_CNT_MAX) begin
            rxCount_next = rxCount_reg + 4'h1;
          end
          state_next = reqLast ? mch_pkg::ST_EXEC : mch_pkg::ST_RECV;
        end
      end
      mch_pkg::ST_EXEC: begin
        // single-cycle evaluation keeps the answer latency fixed
        // outputs and answer change together, one cycle after the last byte
        out_next = execOut;
        upd_next = execUpd;
        txBuf_next = execBuf;
        txLeft_next = execLen;
        state_next = mch_pkg::ST_SEND;
      end
      mch_pkg::ST_SEND: begin
        // a stalled consumer simply holds the byte; nothing times out here
        // limitation: a master that never accepts keeps the request port shut
        if (rspReady) begin
          for (int i = 0; i < mch_pkg::TX_BYTES - 1; i++) begin
            txBuf_next[i] = txBuf_reg[i + 1];
          end
          txBuf_next[mch_pkg::TX_BYTES - 1] = 8'h00;
          txLeft_next = txLeft_reg - 3'h1;
          if (txLeft_reg == 3'h1) begin
            rxCount_next = 4'h0; // ready for the next request
            state_next = mch_pkg::ST_IDLE;
          end
        end
      end
    endcase
  end

  // reset returns the port to idle with outputs off; a frame cut by reset
  // is lost and no answer is sent for it
  // registers of the sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= mch_pkg::ST_IDLE;
      for (int i = 0; i < mch_pkg::RX_BYTES; i++) begin
        rxBuf_reg[i] <= 8'h00;
      end
      for (int i = 0; i < mch_pkg::TX_BYTES; i++) begin
        txBuf_reg[i] <= 8'h00;
      end
      rxCount_reg <= 4'h0;
      txLeft_reg <= 3'h0;
      out_reg <= mch_pkg::OUT_RESET;
      upd_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      rxBuf_reg <= rxBuf_next;
      txBuf_reg <= txBuf_next;
      rxCount_reg <= rxCount_next;
      txLeft_reg <= txLeft_next;
      out_reg <= out_next;
      upd_reg <= upd_next;
    end
  end

  // reqReady and rspValid are never high together, which keeps the
  // request and answer phases strictly apart for the far-side master
  // rspLast rides with the final byte only, taken from the byte counter
  // handshake outputs are decoded from state; data from flops
  assign reqReady = (state_reg == mch_pkg::ST_IDLE) || (state_reg == mch_pkg::ST_RECV);
  assign rspValid = (state_reg == mch_pkg::ST_SEND);
  assign rspData = txBuf_reg[0];
  assign rspLast = (state_reg == mch_pkg::ST_SEND) && (txLeft_reg == 3'h1);
  assign digitalOut = out_reg;
  assign outputsUpdated = upd_reg;

  // the capture is independent of the slave path above; it watches a
  // separate byte stream and shares only the clock and reset
  // master-role capture of returned codes and status data
  mch_resp_capture u_capture (
    .clk(clk),
    .rst(rst),
    .mstValid(mstValid),
    .mstData(mstData),
    .mstLast(mstLast),
    .mstDestIndex(mstDestIndex),
    .responseFunctionCodeQuery(responseFunctionCodeQuery),
    .responseExceptionCodeQuery(responseExceptionCodeQuery),
    .arrayWrite(arrayWrite),
    .arrayIndex(arrayIndex),
    .arrayData(arrayData)
  );

endmodule // mch_coil_handler

// file: sim/mch_coil_handler_properties.sv
// port-level assertions for the output coil request handler
module mch_coil_handler_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request stream
  input wire logic reqValid,
  input wire logic reqLast,
  input wire logic reqReady,
  // response stream
  input wire logic rspValid,
  input wire logic [7:0] rspData,
  input wire logic rspLast,
  input wire logic rspReady,
  // digital outputs
  input wire logic [15:0] digitalOut,
  input wire logic outputsUpdated,
  // master-role capture
  input wire logic mstValid,
  input wire logic [7:0] mstData,
  input wire logic mstLast,
  input wire logic [7:0] responseFunctionCodeQuery,
  input wire logic [7:0] responseExceptionCodeQuery,
  input wire logic arrayWrite,
  input wire logic [7:0] arrayData
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic rspFirst_reg, rspFirst_next; // next response byte is a function code
  logic mstFirst_reg, mstFirst_next; // next master-role byte is a function code
  // first-byte trackers; a byte inside a frame may equal a function code
  always_comb begin
    rspFirst_next = rspFirst_reg;
    mstFirst_next = mstFirst_reg;
    if (rspValid && rspReady) begin
      rspFirst_next = rspLast;
    end
    if (mstValid) begin
      mstFirst_next = mstLast;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      rspFirst_reg <= 1'b1;
      mstFirst_reg <= 1'b1;
    end else begin
      rspFirst_reg <= rspFirst_next;
      mstFirst_reg <= mstFirst_next;
    end
  end
  reset_clear_a: assert property (disable iff (1'b0) rst |=> digitalOut == 16'h0000 && !rspValid && reqReady)
    else $error("outputs or handshake not cleared by reset");
  answer_turn_a: assert property (reqValid && reqReady && reqLast |=> !reqReady && !rspValid ##1 rspValid)
    else $error("response not started two cycles after last request byte");
  rsp_hold_a: assert property (rspValid && !rspReady |=> rspValid && $stable(rspData) && $stable(rspLast))
    else $error("response byte changed while stalled");
  busy_refuse_a: assert property (rspValid |-> !reqReady)
    else $error("request accepted while answering");
  out_change_a: assert property ($changed(digitalOut) |-> outputsUpdated && $rose(rspValid))
    else $error("outputs changed without an accepted write");
  exc_no_write_a: assert property ($rose(rspValid) && rspData[7] |-> !outputsUpdated)
    else $error("exception answer wrote outputs");
  exc_code_a: assert property (rspFirst_reg && rspValid && rspReady && rspData[7]
    |=> rspValid && rspLast && rspData inside {8'h01, 8'h02, 8'h03})
    else $error("exception answer code malformed");
  status_byte_a: assert property (rspFirst_reg && rspValid && rspReady && rspData == 8'h07
    |=> rspValid && rspLast && rspData == digitalOut[7:0])
    else $error("status byte differs from outputs 7..0");
  fc_keep_a: assert property (mstValid && mstFirst_reg |=> responseFunctionCodeQuery == $past(mstData))
    else $error("response function code not kept");
  exc_keep_a: assert property (mstValid && mstFirst_reg && mstData[7] ##1 mstValid
    |=> responseExceptionCodeQuery == $past(mstData))
    else $error("exception code not kept");
  array_store_a: assert property (mstValid && mstFirst_reg && mstData == 8'h07 ##1 mstValid
    |=> arrayWrite && arrayData == $past(mstData))
    else $error("status byte not stored");
  status_seen_c: cover property (rspFirst_reg && rspValid && rspReady && rspData == 8'h07);
  exc_seen_c: cover property (rspFirst_reg && rspValid && rspData[7]);
  array_seen_c: cover property (arrayWrite);
endmodule // mch_coil_handler_checker

bind mch_coil_handler mch_coil_handler_checker u_checker (.clk(clk), .rst(rst), .reqValid(reqValid),
  .reqLast(reqLast), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .rspLast(rspLast),
  .rspReady(rspReady), .digitalOut(digitalOut), .outputsUpdated(outputsUpdated), .mstValid(mstValid),
  .mstData(mstData), .mstLast(mstLast), .responseFunctionCodeQuery(responseFunctionCodeQuery),
  .responseExceptionCodeQuery(responseExceptionCodeQuery), .arrayWrite(arrayWrite), .arrayData(arrayData));

// file: sim/mch_master_model.sv
// far-side request master: sends request frames and collects the answer bytes
module mch_master_model (
  // clock
  input wire logic clk,
  // request stream toward the handler
  output logic reqValid,
  output logic [7:0] reqData,
  output logic reqLast,
  input wire logic reqReady,
  // response stream from the handler
  input wire logic rspValid,
  input wire logic [7:0] rspData,
  input wire logic rspLast,
  output logic rspReady
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rsp[$]; // bytes of the current answer
  logic gotLast = 1'b0; // final answer byte taken
  bit stall = 1'b0; // slow consumer: accept every other cycle
  initial begin
    reqValid = 1'b0;
    reqData = 8'h00;
    reqLast = 1'b0;
    rspReady = 1'b1;
  end
  // one whole frame, bytes held until taken
  task automatic send(input logic [7:0] b[$]);
    logic ok;
    for (int i = 0; i < b.size(); i++) begin
      reqValid = 1'b1;
      reqData = b[i];
      reqLast = (i == b.size() - 1);
      do begin
        ok = reqReady;
        @(posedge clk);
        #1;
      end while (!ok);
    end
    reqValid = 1'b0;
    reqLast = 1'b0;
    reqData = ~reqData; // released bus never shows the stale byte
  endtask
  // acceptance pacing
  always @(posedge clk) rspReady <= #1 (stall ? ~rspReady : 1'b1);
  // collect accepted answer bytes
  always @(posedge clk) begin
    if (rspValid && rspReady) begin
      rsp.push_back(rspData);
      if (rspLast) begin
        gotLast <= 1'b1;
      end
    end
  end
endmodule // mch_master_model

// file: sim/testbench.sv
// self-checking testbench of the output coil request handler
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0; // 25 MHz
  logic rst = 1'b1; // synchronous, active high
  logic reqValid, reqLast, reqReady, rspValid, rspLast, rspReady, outputsUpdated, arrayWrite;
  logic [7:0] reqData, rspData, fcQuery, excQuery, arrayIndex, arrayData;
  logic [15:0] digitalOut;
  logic mstValid = 1'b0; // master-role answer stream, driven here
  logic mstLast = 1'b0;
  logic [7:0] mstData = 8'h00;
  logic [7:0] mstDestIndex = 8'h00;
  int mismatches = 0;
  int n_compared = 0;
  int updPulses = 0; // outputs-written pulses seen
  mch_coil_handler u_dut (.clk(clk), .rst(rst), .reqValid(reqValid), .reqData(reqData), .reqLast(reqLast),
    .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .rspLast(rspLast), .rspReady(rspReady),
    .digitalOut(digitalOut), .outputsUpdated(outputsUpdated), .mstValid(mstValid), .mstData(mstData),
    .mstLast(mstLast), .mstDestIndex(mstDestIndex), .responseFunctionCodeQuery(fcQuery),
    .responseExceptionCodeQuery(excQuery), .arrayWrite(arrayWrite), .arrayIndex(arrayIndex), .arrayData(arrayData));
  mch_master_model u_master (.clk(clk), .reqValid(reqValid), .reqData(reqData), .reqLast(reqLast),
    .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .rspLast(rspLast), .rspReady(rspReady));
  // clock
  initial begin
    forever #20 clk = ~clk;
  end
  // count write pulses, sampled like a flop on each edge
  always @(posedge clk) begin
    if (outputsUpdated) begin
      updPulses++;
    end
  end
  // one comparison
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // one request, its answer bytes and the outputs afterwards
  task automatic xact(input logic [7:0] req[$], input logic [7:0] exp[$], input logic [15:0] expOut);
    int w;
    int u0; // pulse count before the request
    u0 = updPulses;
    u_master.rsp.delete();
    u_master.gotLast = 1'b0;
    u_master.send(req);
    w = 0;
    while (!u_master.gotLast && w < 200) begin
      @(posedge clk);
      w++;
    end
    #1;
    check("answer length", 16'(u_master.rsp.size()), 16'(exp.size()));
    foreach (exp[i]) begin
      if (i < u_master.rsp.size()) begin
        check("answer byte", u_master.rsp[i], exp[i]);
      end
    end
    check("digitalOut", digitalOut, expOut);
    check("outputsUpdated", 16'(updPulses - u0), 16'(exp.size() == 5));
  endtask
  // two-byte master-role answer, then the kept results
  task automatic mst(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] idx, input logic aw);
    mstValid = 1'b1;
    mstData = b0;
    mstDestIndex = idx;
    @(posedge clk);
    #1;
    mstData = b1;
    mstLast = 1'b1;
    @(posedge clk);
    #1;
    mstValid = 1'b0;
    mstLast = 1'b0;
    mstData = ~b1; // idle stream never repeats the last byte
    check("fc query", fcQuery, b0);
    check("exc query", excQuery, b0[7] ? b1 : 8'h00);
    check("arrayWrite", arrayWrite, aw);
    if (aw) begin
      check("arrayData", arrayData, b1);
      check("arrayIndex", arrayIndex, idx);
    end
    // one idle edge so back-to-back calls never re-drive the stream in one step
    @(posedge clk);
    #1;
  endtask
  // reset state
  task automatic t_reset();
    check("digitalOut", digitalOut, 16'h0000);
    check("rspValid", rspValid, 1'b0);
    check("fc query", fcQuery, 8'h00);
  endtask
  // single coil: on, last address, off, bad value, bad address
  task automatic t_single_coil();
    xact({8'h05, 8'h00, 8'h07, 8'hFF, 8'h00}, {8'h05, 8'h00, 8'h07, 8'hFF, 8'h00}, 16'h0080);
    xact({8'h05, 8'h00, 8'h0F, 8'hFF, 8'h00}, {8'h05, 8'h00, 8'h0F, 8'hFF, 8'h00}, 16'h8080);
    xact({8'h05, 8'h00, 8'h07, 8'h00, 8'h00}, {8'h05, 8'h00, 8'h07, 8'h00, 8'h00}, 16'h8000);
    xact({8'h05, 8'h00, 8'h03, 8'h12, 8'h34}, {8'h85, 8'h03}, 16'h8000);
    xact({8'h05, 8'h00, 8'h10, 8'hFF, 8'h00}, {8'h85, 8'h02}, 16'h8000);
  endtask
  // preset register, good and bad address; slow consumer on the status read
  task automatic t_preset_status();
    xact({8'h06, 8'h00, 8'h00, 8'h55, 8'hAA}, {8'h06, 8'h00, 8'h00, 8'h55, 8'hAA}, 16'h55AA);
    xact({8'h06, 8'h00, 8'h01, 8'hFF, 8'hFF}, {8'h86, 8'h02}, 16'h55AA);
    u_master.stall = 1'b1;
    xact({8'h07}, {8'h07, 8'hAA}, 16'h55AA);
    u_master.stall = 1'b0;
  endtask
  // multiple coils: all sixteen, partial range, bad quantity and overrun, unknown code
  task automatic t_multi_coils();
    xact({8'h0F, 8'h00, 8'h00, 8'h00, 8'h10, 8'h02, 8'h55, 8'hAA},
      {8'h0F, 8'h00, 8'h00, 8'h00, 8'h10}, 16'hAA55);
    xact({8'h07}, {8'h07, 8'h55}, 16'hAA55);
    xact({8'h0F, 8'h00, 8'h04, 8'h00, 8'h03, 8'h01, 8'h02},
      {8'h0F, 8'h00, 8'h04, 8'h00, 8'h03}, 16'hAA25);
    xact({8'h0F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, {8'h8F, 8'h02}, 16'hAA25);
    xact({8'h0F, 8'h00, 8'h0F, 8'h00, 8'h02, 8'h01, 8'h03}, {8'h8F, 8'h02}, 16'hAA25);
    xact({8'h2B}, {8'hAB, 8'h01}, 16'hAA25);
  endtask
  // master-role capture: exception then status with store
  task automatic t_master();
    mst(8'h85, 8'h02, 8'h00, 1'b0);
    mst(8'h07, 8'hAA, 8'h03, 1'b1);
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_single_coil();
    t_preset_status();
    t_multi_coils();
    t_master();
    tally_and_finish();
  end
  // watchdog: the run needs well under a thousand cycles
  initial begin
    #800000;
    mismatches++;
    tally_and_finish();
  end
endmodule // testbench
